// file: hw/wwd_defs.svh
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

`define WWD_PRESC_W 14
`define WWD_PRESC_MAX 14'h3fff
`define WWD_CNT_W 7
`define WWD_CNT_RST 7'h7f
`define WWD_CNT_STEP 7'h01
`define WWD_ACT_BIT 7
`define WWD_MSB_BIT 6
`define WWD_CLK_NS 100
`define WWD_RST_NS 500
`define WWD_RST_CYC ((`WWD_RST_NS + `WWD_CLK_NS - 1) / `WWD_CLK_NS)
`define WWD_PULSE_W 3
`define WWD_WAKE_SHORT 256
`define WWD_WAKE_LONG 4096
`define WWD_WAKE_W 12

`endif

// file: hw/wwd_pkg.sv
`default_nettype none
package wwd_pkg;
  typedef enum logic [1:0] {
    WWD_RUN = 2'b00,
    WWD_HALT_LAST = 2'b01,
    WWD_HALTED = 2'b10,
    WWD_WAKE = 2'b11
  } wwd_state_t;
endpackage
`default_nettype wire

// file: hw/wwd_presc_if.sv
`default_nettype none
interface wwd_presc_if;
  logic run;
  logic tick;
  modport ctrl (output run, input tick);
  modport presc (input run, output tick);
endinterface
`default_nettype wire

// file: hw/wwd_prescaler.sv
`include "wwd_defs.svh"
`default_nettype none
module wwd_prescaler (
  input wire logic clk,
  input wire logic rst_n,
  wwd_presc_if.presc pif
);
  logic [`WWD_PRESC_W-1:0] pre_reg;
  logic tick_reg;
  logic [`WWD_PRESC_W-1:0] gap_reg;

  // Frozen, never cleared, so a counter load keeps the phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else if (pif.run) begin
      pre_reg <= pre_reg + `WWD_PRESC_W'(1);
    end
  end

  // R1: one tick per wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= pif.run && (pre_reg == `WWD_PRESC_MAX);
    end
  end

  assign pif.tick = tick_reg;

  // Running cycles since the last tick, for checking only
  // Reaches the max value in the same cycle as each tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= `WWD_PRESC_MAX;
    end else if (tick_reg) begin
      gap_reg <= pif.run ? '0 : `WWD_PRESC_MAX;
    end else if (pif.run) begin
      gap_reg <= gap_reg + `WWD_PRESC_W'(1);
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (!rst_n)
    tick_reg |-> (gap_reg == `WWD_PRESC_MAX);
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong"); // R1
endmodule
`default_nettype wire

// file: hw/wwd_top.sv
// How it works
// R1: Counter steps down once per 16384 reference clocks through a hidden prescaler.
// R2: Six low counter bits loaded by software set timeout in 64 steps.
// R3: Active and counter passing 40h to 3Fh drives reset low about 500 ns.
// R4: Counter runs down always, whether or not the watchdog is active; the code holds it once halted and during the wake delay.
// R5: Software refreshes with values C0h to FFh, both top bits set.
// R6: A write loads the counter but leaves the prescaler phase alone.
// R7: After device reset the watchdog starts inactive; with HW_MODE_OPT set the code starts it active.
// R8: Activation bit cannot be cleared by software, only by device reset.
// R9: Writing activation set with counter top bit clear forces immediate reset.
// R10: Active watchdog with halt option turns HALT into a device reset.
// R11: Option input chooses whether HALT while active causes reset.
// R12: Option input selects hardware watchdog mode besides software activation.
// R13: Hardware mode is active from reset; activation bit then ignored.
// R14: Control register resets to 7Fh: activation bit 7, counter bits 6..0.
// R15: Halt decrements once then stops; wake restarts after 256 or 4096 clocks.
// R16: Inactive counter wraps 00h to 7Fh without asserting reset.
`include "wwd_defs.svh"
`default_nettype none
module wwd_top (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic WR_STB,
  input wire logic [7:0] WR_DATA,
  input wire logic HW_MODE_OPT,
  input wire logic HALT_RST_OPT,
  input wire logic HALT_EXEC,
  input wire logic WAKE_IRQ,
  input wire logic WAKE_LONG,
  output logic [7:0] RD_DATA,
  output logic RESET_PIN_N,
  output logic HALT_ENTER,
  output logic ACTIVE
);
  wwd_presc_if pif();
  wwd_pkg::wwd_state_t state_reg;
  wwd_pkg::wwd_state_t state_next;
  logic act_reg;
  logic act_next;
  logic [`WWD_CNT_W-1:0] cnt_reg;
  logic [`WWD_CNT_W-1:0] cnt_next;
  logic [`WWD_PULSE_W-1:0] pulse_reg;
  logic [`WWD_WAKE_W-1:0] wake_reg;
  logic active;
  logic active_next;
  logic tick;
  logic halt_rst;
  logic halt_go;
  logic trip;

  // A reset is due when active and the counter top bit is clear
  function automatic logic fires(input logic act, input logic [`WWD_CNT_W-1:0] cnt);
    fires = act && !cnt[`WWD_MSB_BIT];
  endfunction

  wwd_prescaler u_presc (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .pif(pif)
  );

  // R15: prescaler frozen once the halt decrement is done
  assign pif.run = (state_reg == wwd_pkg::WWD_RUN) || (state_reg == wwd_pkg::WWD_HALT_LAST);
  assign tick = pif.tick;

  // R12: hardware mode overrides the activation bit
  // R13: hardware mode always active
  assign active = act_reg || HW_MODE_OPT;
  // R8: software can only set the activation bit
  assign act_next = act_reg || (WR_STB && WR_DATA[`WWD_ACT_BIT]);
  assign active_next = act_next || HW_MODE_OPT;

  // R11: option decides between halt reset and real halt
  assign halt_rst = HALT_EXEC && (state_reg == wwd_pkg::WWD_RUN) && active && HALT_RST_OPT;
  assign halt_go = HALT_EXEC && (state_reg == wwd_pkg::WWD_RUN) && !(active && HALT_RST_OPT);

  // R6: a load wins over a tick in the same cycle
  always_comb begin
    if (WR_STB) begin
      // R2: load sets timeout
      cnt_next = WR_DATA[`WWD_CNT_W-1:0];
    end else if (tick) begin
      // R16: plain 7-bit wrap from 00h to 7Fh
      cnt_next = cnt_reg - `WWD_CNT_STEP;
    end else begin
      cnt_next = cnt_reg;
    end
  end

  // R3: top bit falling on a tick; R9: forced by a write; R10: halt
  assign trip = (WR_STB && fires(active_next, WR_DATA[`WWD_CNT_W-1:0]))
             || (!WR_STB && tick && cnt_reg[`WWD_MSB_BIT] && fires(active, cnt_next))
             || halt_rst;

  // R7: activation bit comes up clear after any device reset
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      act_reg <= 1'b0;
    end else begin
      act_reg <= act_next;
    end
  end

  // R14: counter reset value; R4: never gated by activation
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_reg <= `WWD_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // R3: retrigger restarts the full pulse, never shortens it
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pulse_reg <= '0;
    end else if (trip) begin
      pulse_reg <= `WWD_PULSE_W'(`WWD_RST_CYC);
    end else if (pulse_reg != '0) begin
      pulse_reg <= pulse_reg - `WWD_PULSE_W'(1);
    end
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RESET_PIN_N <= 1'b1;
    end else begin
      RESET_PIN_N <= !(trip || (pulse_reg > `WWD_PULSE_W'(1)));
    end
  end

  // R15: halt sequencing
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      wwd_pkg::WWD_RUN: begin
        if (halt_go) begin
          state_next = wwd_pkg::WWD_HALT_LAST;
        end
      end
      wwd_pkg::WWD_HALT_LAST: begin
        if (WAKE_IRQ) begin
          state_next = wwd_pkg::WWD_WAKE;
        end else if (tick) begin
          state_next = wwd_pkg::WWD_HALTED;
        end
      end
      wwd_pkg::WWD_HALTED: begin
        if (WAKE_IRQ) begin
          state_next = wwd_pkg::WWD_WAKE;
        end
      end
      wwd_pkg::WWD_WAKE: begin
        if (wake_reg == '0) begin
          state_next = wwd_pkg::WWD_RUN;
        end
      end
      default: begin
        state_next = wwd_pkg::WWD_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= wwd_pkg::WWD_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // R15: wake delay counts down to zero, then counting resumes
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      wake_reg <= '0;
    end else if (state_reg != wwd_pkg::WWD_WAKE && state_next == wwd_pkg::WWD_WAKE) begin
      wake_reg <= WAKE_LONG ? `WWD_WAKE_W'(`WWD_WAKE_LONG - 1)
                            : `WWD_WAKE_W'(`WWD_WAKE_SHORT - 1);
    end else if (wake_reg != '0) begin
      wake_reg <= wake_reg - `WWD_WAKE_W'(1);
    end
  end

  // Registered from next values, so a write shows at its own edge
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      RD_DATA <= {1'b0, `WWD_CNT_RST};
      HALT_ENTER <= 1'b0;
      ACTIVE <= 1'b0;
    end else begin
      RD_DATA <= {act_next, cnt_next};
      HALT_ENTER <= halt_go;
      ACTIVE <= active_next;
    end
  end

  property p_msb_trip;
    @(posedge REF_CLK) disable iff (!RESETN)
    (active && tick && !WR_STB && cnt_reg == {1'b1, {(`WWD_CNT_W-1){1'b0}}})
      |=> !RESET_PIN_N && cnt_reg == {1'b0, {(`WWD_CNT_W-1){1'b1}}};
  endproperty
  a_msb_trip: assert property (p_msb_trip) else $error("no reset at 40h to 3Fh"); // R3

  property p_pulse_width;
    @(posedge REF_CLK) disable iff (!RESETN)
    $fell(RESET_PIN_N) |-> (!RESET_PIN_N)[*5];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("reset pulse too short"); // R3

  property p_free_run;
    @(posedge REF_CLK) disable iff (!RESETN)
    (tick && !WR_STB) |=> cnt_reg == `WWD_CNT_W'($past(cnt_reg) - `WWD_CNT_STEP);
  endproperty
  a_free_run: assert property (p_free_run) else $error("counter missed a tick"); // R4

  property p_load;
    @(posedge REF_CLK) disable iff (!RESETN)
    WR_STB |=> cnt_reg == $past(WR_DATA[`WWD_CNT_W-1:0])
      && RD_DATA[`WWD_CNT_W-1:0] == $past(WR_DATA[`WWD_CNT_W-1:0]);
  endproperty
  a_load: assert property (p_load) else $error("write did not load counter"); // R6

  property p_sticky;
    @(posedge REF_CLK) disable iff (!RESETN)
    act_reg |=> act_reg && RD_DATA[`WWD_ACT_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("activation bit cleared"); // R8

  property p_force;
    @(posedge REF_CLK) disable iff (!RESETN)
    (WR_STB && WR_DATA[`WWD_ACT_BIT] && !WR_DATA[`WWD_MSB_BIT]) |=> !RESET_PIN_N ##1 !RESET_PIN_N;
  endproperty
  a_force: assert property (p_force) else $error("forced reset missing"); // R9

  property p_halt_rst;
    @(posedge REF_CLK) disable iff (!RESETN)
    (HALT_EXEC && state_reg == wwd_pkg::WWD_RUN && active && HALT_RST_OPT)
      |=> !RESET_PIN_N && !HALT_ENTER;
  endproperty
  a_halt_rst: assert property (p_halt_rst) else $error("halt did not reset"); // R10

  property p_hw_mode;
    @(posedge REF_CLK) disable iff (!RESETN)
    HW_MODE_OPT |=> ACTIVE;
  endproperty
  a_hw_mode: assert property (p_hw_mode) else $error("hardware mode not active"); // R13

  property p_halt_freeze;
    @(posedge REF_CLK) disable iff (!RESETN)
    (state_reg == wwd_pkg::WWD_HALTED && !WR_STB) |=> cnt_reg == $past(cnt_reg) && !tick;
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in halt"); // R15

  property p_wrap;
    @(posedge REF_CLK) disable iff (!RESETN)
    (!active_next && tick && !WR_STB && cnt_reg == '0 && RESET_PIN_N && pulse_reg == '0)
      |=> cnt_reg == `WWD_CNT_RST ##1 RESET_PIN_N;
  endproperty
  a_wrap: assert property (p_wrap) else $error("inactive wrap misbehaved"); // R16
endmodule
`default_nettype wire

// file: test/wwd_top_tb.sv
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module wwd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr_stb = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic hw_mode_opt = 1'b0;
  logic halt_rst_opt = 1'b0;
  logic halt_exec = 1'b0;
  logic wake_irq = 1'b0;
  logic wake_long = 1'b0;
  logic [7:0] rd_data;
  logic reset_pin_n;
  logic halt_enter;
  logic active;
  logic rst_seen = 1'b0;
  logic halt_seen = 1'b0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  int t1;

  wwd_top wwd_top_i (
    .REF_CLK(ref_clk),
    .RESETN(resetn),
    .WR_STB(wr_stb),
    .WR_DATA(wr_data),
    .HW_MODE_OPT(hw_mode_opt),
    .HALT_RST_OPT(halt_rst_opt),
    .HALT_EXEC(halt_exec),
    .WAKE_IRQ(wake_irq),
    .WAKE_LONG(wake_long),
    .RD_DATA(rd_data),
    .RESET_PIN_N(reset_pin_n),
    .HALT_ENTER(halt_enter),
    .ACTIVE(active)
  );

  always #50 ref_clk = ~ref_clk;
  // Stamps taken at posedge so gaps are exact whatever phase we sample at
  always @(posedge ref_clk) cyc <= cyc + 1;
  always @(negedge reset_pin_n) rst_seen = 1'b1;
  always @(posedge halt_enter) halt_seen = 1'b1;

  task automatic wr(input logic [7:0] d);
    @(negedge ref_clk);
    wr_stb = 1'b1;
    wr_data = d;
    @(negedge ref_clk);
    wr_stb = 1'b0;
  endtask

  task automatic halt_req();
    @(negedge ref_clk);
    halt_exec = 1'b1;
    @(negedge ref_clk);
    halt_exec = 1'b0;
  endtask

  // Wake pulse, then n idle cycles
  task automatic wake(input logic lng, input int n);
    @(negedge ref_clk);
    wake_long = lng;
    wake_irq = 1'b1;
    @(negedge ref_clk);
    wake_irq = 1'b0;
    wake_long = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic pulse(input string nm);
    int n = 0;
    int w = 0;
    while (reset_pin_n !== 1'b0 && w < 20) begin
      w++;
      @(negedge ref_clk);
    end
    while (reset_pin_n === 1'b0 && n < 20) begin
      n++;
      @(negedge ref_clk);
    end
    `CHK(nm, 5, n)
  endtask

  // Bounded a little above one prescaler period
  task automatic wait_chg(output int t);
    logic [7:0] p;
    int w;
    p = rd_data;
    w = 0;
    while (rd_data === p && w < 17000) begin
      w++;
      @(negedge ref_clk);
    end
    t = cyc;
  endtask

  task automatic rst(input logic hw);
    @(negedge ref_clk);
    resetn = 1'b0;
    hw_mode_opt = hw;
    repeat (12) @(negedge ref_clk);
    `CHK("rd_data", 8'h7f, rd_data)
    `CHK("reset_pin_n", 1'b1, reset_pin_n)
    `CHK("active", 1'b0, active)
    resetn = 1'b1;
    @(negedge ref_clk);
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge ref_clk);
    n_mismatch++;
    $display("ERROR watchdog expected done seen timeout");
    close_out();
  end

  initial begin
    rst(1'b0);
    `CHK("active", 1'b0, active)
    wr(8'h01);
    `CHK("rd_data", 8'h01, rd_data)
    rst_seen = 1'b0;
    wait_chg(t0);
    `CHK("rd_data", 8'h00, rd_data)
    wait_chg(t1);
    `CHK("rd_data", 8'h7f, rd_data)
    `CHK("tick gap", 16384, t1 - t0)
    `CHK("reset seen", 1'b0, rst_seen)
    $display("Test wrap done");
    // Refresh mid-period: prescaler phase must survive the write
    repeat (8000) @(negedge ref_clk);
    wr(8'hc1);
    `CHK("rd_data", 8'hc1, rd_data)
    `CHK("active", 1'b1, active)
    wait_chg(t0);
    `CHK("rd_data", 8'hc0, rd_data)
    `CHK("tick gap", 16384, t0 - t1)
    wait_chg(t1);
    `CHK("rd_data", 8'hbf, rd_data)
    pulse("timeout pulse");
    $display("Test timeout done");
    wr(8'h7f);
    `CHK("rd_data", 8'hff, rd_data)
    `CHK("active", 1'b1, active)
    wr(8'h80);
    pulse("forced pulse");
    $display("Test activation done");
    halt_rst_opt = 1'b0;
    rst_seen = 1'b0;
    halt_req();
    `CHK("halt_enter", 1'b1, halt_enter)
    // One more decrement in halt, then frozen
    wait_chg(t0);
    `CHK("rd_data", 8'hff, rd_data)
    `CHK("tick gap", 16384, t0 - t1)
    repeat (100) @(negedge ref_clk);
    `CHK("rd_data", 8'hff, rd_data)
    `CHK("reset seen", 1'b0, rst_seen)
    // Long wake: a halt on the last delay cycle is still refused
    halt_rst_opt = 1'b1;
    wake(1'b1, 4094);
    halt_req();
    `CHK("halt_enter", 1'b0, halt_enter)
    `CHK("reset seen", 1'b0, rst_seen)
    halt_seen = 1'b0;
    halt_req();
    pulse("halt pulse");
    `CHK("halt seen", 1'b0, halt_seen)
    $display("Test halt done");
    rst(1'b0);
    `CHK("active", 1'b0, active)
    halt_req();
    `CHK("halt_enter", 1'b1, halt_enter)
    // Short wake: refused on the last delay cycle, taken just after
    wake(1'b0, 254);
    halt_req();
    `CHK("halt_enter", 1'b0, halt_enter)
    halt_req();
    `CHK("halt_enter", 1'b1, halt_enter)
    $display("Test wake done");
    rst(1'b1);
    `CHK("active", 1'b1, active)
    wr(8'h7f);
    `CHK("active", 1'b1, active)
    halt_req();
    pulse("hw halt pulse");
    $display("Test hardware mode done");
    close_out();
  end
endmodule
`default_nettype wire
